// ==== inc/sensor_ctrl_pkg.sv ====
package sensor_ctrl_pkg;
   // register offsets
   localparam logic [7:0] OFS_CONFIG = 8'h70;
   localparam logic [7:0] OFS_LAMP = 8'h74;
   localparam logic [7:0] OFS_PIN = 8'hBE;
   localparam logic [7:0] OFS_IRQ_EN = 8'hF9;
   localparam logic [7:0] OFS_ACTION = 8'hFA;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
   localparam logic [7:0] OFS_IRQ_MASK = 8'hF1;
   // field positions
   localparam int POS_PIN_INV = 3;
   localparam int POS_PIN_IN_EN = 2;
   localparam int POS_PIN_OUT = 1;
   localparam int POS_PIN_IN = 0;
   localparam int POS_LAMP_ON = 7;
   localparam int POS_LAMP_SEL = 3;
   localparam int POS_SAT_IEN = 7;
   localparam int POS_SPEC_IEN = 3;
   localparam int POS_BUF_IEN = 2;
   localparam int POS_SYS_IEN = 0;
   localparam int POS_ZERO = 2;
   localparam int POS_FLUSH = 1;
   localparam int POS_WAKE = 0;
   // status bit positions (same layout as mask)
   localparam int POS_EV_SAT = 0;
   localparam int POS_EV_SPEC = 1;
   localparam int POS_EV_BUF = 2;
   localparam int POS_EV_SYS = 3;
   // reset values and writable masks
   localparam logic [7:0] RST_PIN = 8'h02;
   localparam logic [6:0] RST_LAMP_CODE = 7'h04;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] WMASK_PIN = 8'h0E;
   localparam logic [7:0] WMASK_IRQ_EN = 8'h8D;
   localparam logic [3:0] WMASK_EVENTS = 4'hF;
   // source events and one-shot actions
   typedef struct packed {
      logic saturation;
      logic spectral;
      logic bufferLevel;
      logic system;
   } events_t;
   typedef struct packed {
      logic manualZeroStart;
      logic bufferFlush;
      logic wakeFromIrqSleep;
   } actions_t;
endpackage

// ==== hdl/sensor_pin_lamp_irq_control.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - a set invert bit flips the level driven on the general-purpose pin.
// - a set input-enable bit turns the pin into an input and stops driving it.
// - the output-drive bit resets to one and sets the pin's active output state directly.
// - bit 0 reads the synchronised pin level while input is enabled.
// - the lamp-on bit switches the lamp on when one and off when zero, reset zero.
// - the seven-bit current code selects 4mA plus 2mA per step and resets to 4.
// - the lamp register drives the lamp pin only while the lamp-select bit at 0x70 is set.
// - saturation events raise interrupts only while the saturation enable is set.
// - spectral events are gated by the spectral enable, which is also given out as a mirror.
// - buffer-level events are gated by the buffer interrupt enable.
// - system events are gated by the system interrupt enable.
// - writing one to control bit 2 starts a manual autozero.
// - writing one to control bit 1 flushes the buffer and its flag, overflow and count.
// - writing one to control bit 0 clears the sleep flag and restarts operation.
module sensor_pin_lamp_irq_control
   import sensor_ctrl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOutEn,
   output logic lampDriverPin,
   output logic [6:0] lampCurrentCode,
   input wire sensor_ctrl_pkg::events_t sourceEvents,
   output sensor_ctrl_pkg::actions_t actionPulses,
   output logic spectralIrqMirror,
   output logic irqOut
);
   import sensor_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register storage
   logic [7:0] pinCfg;
   logic [7:0] lampReg;
   logic [7:0] configReg;
   logic [7:0] irqEnables;
   logic [3:0] irqStatus;
   logic [3:0] irqMask;
   logic pinSync1;
   logic pinSync2;
   logic [3:0] gatedEvents;
   logic [3:0] next_status;
   logic [7:0] next_rdData;

   // write decode helper
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin configuration register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pinCfg <= RST_PIN;
      end else if (regWrite && hit(regAddr, OFS_PIN)) begin
         pinCfg <= regWrData & WMASK_PIN;
      end
   end

   // lamp and configuration registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lampReg <= {1'b0, RST_LAMP_CODE};
         configReg <= RST_ZERO;
      end else if (regWrite) begin
         if (hit(regAddr, OFS_LAMP)) begin
            lampReg <= regWrData;
         end
         if (hit(regAddr, OFS_CONFIG)) begin
            configReg <= regWrData;
         end
      end
   end

   // interrupt enables and mask
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqEnables <= RST_ZERO;
         irqMask <= 4'h0;
      end else if (regWrite) begin
         if (hit(regAddr, OFS_IRQ_EN)) begin
            irqEnables <= regWrData & WMASK_IRQ_EN;
         end
         if (hit(regAddr, OFS_IRQ_MASK)) begin
            irqMask <= regWrData[3:0] & WMASK_EVENTS;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchroniser
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
      end else begin
         pinSync1 <= pinIn;
         pinSync2 <= pinSync1;
      end
   end

   // pin and lamp drive
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pinOut <= 1'b0;
         pinOutEn <= 1'b0;
         lampDriverPin <= 1'b0;
         lampCurrentCode <= RST_LAMP_CODE;
         spectralIrqMirror <= 1'b0;
      end else begin
         pinOut <= pinCfg[POS_PIN_OUT] ^ pinCfg[POS_PIN_INV];
         pinOutEn <= !pinCfg[POS_PIN_IN_EN];
         if (configReg[POS_LAMP_SEL]) begin
            lampDriverPin <= lampReg[POS_LAMP_ON];
            lampCurrentCode <= lampReg[6:0];
         end else begin
            lampDriverPin <= 1'b0;
         end
         spectralIrqMirror <= irqEnables[POS_SPEC_IEN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one-shot actions
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         actionPulses <= '0;
      end else begin
         actionPulses.manualZeroStart <= regWrite && hit(regAddr, OFS_ACTION)
            && regWrData[POS_ZERO];
         actionPulses.bufferFlush <= regWrite && hit(regAddr, OFS_ACTION)
            && regWrData[POS_FLUSH];
         actionPulses.wakeFromIrqSleep <= regWrite && hit(regAddr, OFS_ACTION)
            && regWrData[POS_WAKE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event gating and sticky status
   always_comb begin
      gatedEvents[POS_EV_SAT] = sourceEvents.saturation && irqEnables[POS_SAT_IEN];
      gatedEvents[POS_EV_SPEC] = sourceEvents.spectral && irqEnables[POS_SPEC_IEN];
      gatedEvents[POS_EV_BUF] = sourceEvents.bufferLevel && irqEnables[POS_BUF_IEN];
      gatedEvents[POS_EV_SYS] = sourceEvents.system && irqEnables[POS_SYS_IEN];
      next_status = irqStatus;
      if (regWrite && hit(regAddr, OFS_IRQ_STATUS)) begin
         next_status = irqStatus & ~regWrData[3:0];
      end
      next_status = next_status | gatedEvents; // set wins over clear
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStatus <= 4'h0;
      end else begin
         irqStatus <= next_status;
      end
   end

   // interrupt output level
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= |(next_status & irqMask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      next_rdData = 8'h00;
      unique case (regAddr)
         OFS_PIN: begin
            next_rdData = pinCfg;
            next_rdData[POS_PIN_IN] = pinCfg[POS_PIN_IN_EN] & pinSync2;
         end
         OFS_LAMP: next_rdData = lampReg;
         OFS_CONFIG: next_rdData = configReg;
         OFS_IRQ_EN: next_rdData = irqEnables;
         OFS_ACTION: next_rdData = 8'h00;
         OFS_IRQ_STATUS: next_rdData = {4'h0, irqStatus};
         OFS_IRQ_MASK: next_rdData = {4'h0, irqMask};
         default: next_rdData = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         regRdData <= next_rdData;
      end else begin
         regRdData <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_pin_invert: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $changed(pinCfg) |=> pinOut == ($past(pinCfg[POS_PIN_OUT]) ^ $past(pinCfg[POS_PIN_INV])))
      else $error("pin output level wrong");
   a_pin_input: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pinCfg[POS_PIN_IN_EN] |=> !pinOutEn)
      else $error("pin driven while input");
   a_pin_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_PIN && !pinCfg[POS_PIN_IN_EN] |=> !regRdData[POS_PIN_IN])
      else $error("pin input read while disabled");
   a_lamp_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !configReg[POS_LAMP_SEL] |=> !lampDriverPin)
      else $error("lamp driven without select");
   a_lamp_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
      configReg[POS_LAMP_SEL] && lampReg[POS_LAMP_ON] |=> lampDriverPin)
      else $error("lamp not on");
   a_sat_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sourceEvents.saturation && irqEnables[POS_SAT_IEN] |=> irqStatus[POS_EV_SAT])
      else $error("saturation event lost");
   a_spec_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !irqStatus[POS_EV_SPEC] && !irqEnables[POS_SPEC_IEN] |=> !irqStatus[POS_EV_SPEC])
      else $error("spectral status set while disabled");
   a_buf_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sourceEvents.bufferLevel && irqEnables[POS_BUF_IEN] |=> irqStatus[POS_EV_BUF])
      else $error("buffer event lost");
   a_sys_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sourceEvents.system && irqEnables[POS_SYS_IEN] |=> irqStatus[POS_EV_SYS])
      else $error("system event lost");
   a_zero_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_ACTION && regWrData[POS_ZERO]
      |=> actionPulses.manualZeroStart ##1 !actionPulses.manualZeroStart || $past(regWrite))
      else $error("autozero pulse wrong");
   a_flush_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
      actionPulses.bufferFlush |-> $past(regWrite) && $past(regWrData[POS_FLUSH]))
      else $error("flush without write");
   a_wake_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_ACTION && regWrData[POS_WAKE] |=> actionPulses.wakeFromIrqSleep)
      else $error("wake pulse missing");
   a_action_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_ACTION |=> regRdData == 8'h00)
      else $error("action register not zero");
   a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ##1 irqOut == |(irqStatus & $past(irqMask)))
      else $error("interrupt level wrong");
   a_out_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(rst_b) |-> pinCfg[POS_PIN_OUT])
      else $error("output drive bit not reset high");

   // pin register storage and drive
   a_pin_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_PIN |=> pinCfg == ($past(regWrData) & WMASK_PIN))
      else $error("pin register write wrong");
   a_pin_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !(regWrite && regAddr == OFS_PIN) |=> $stable(pinCfg))
      else $error("pin register changed without write");
   a_pin_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !pinCfg[POS_PIN_IN_EN] |=> pinOutEn)
      else $error("pin not driven as output");
   a_pin_inverted: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pinCfg[POS_PIN_INV] && pinCfg[POS_PIN_OUT] |=> !pinOut)
      else $error("inverted pin level wrong");
   a_pin_direct: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !pinCfg[POS_PIN_INV] && pinCfg[POS_PIN_OUT] |=> pinOut)
      else $error("direct pin level wrong");
   a_pin_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !pinCfg[POS_PIN_INV] && !pinCfg[POS_PIN_OUT] |=> !pinOut)
      else $error("pin driven high without drive bit");
   a_pin_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pinCfg[7:4] == 4'h0 && !pinCfg[POS_PIN_IN])
      else $error("pin reserved bits stored");
   a_pin_sample: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_PIN && pinCfg[POS_PIN_IN_EN]
      |=> regRdData[POS_PIN_IN] == $past(pinSync2))
      else $error("pin input level not reported");
   a_pin_fields: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_PIN |=> regRdData[7:1] == $past(pinCfg[7:1]))
      else $error("pin register read wrong");

   // lamp register and drive
   a_lamp_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_LAMP |=> lampReg == $past(regWrData))
      else $error("lamp register write wrong");
   a_lamp_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
      configReg[POS_LAMP_SEL] |=> lampCurrentCode == $past(lampReg[6:0]))
      else $error("lamp current code wrong");
   a_code_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !configReg[POS_LAMP_SEL] |=> $stable(lampCurrentCode))
      else $error("lamp code changed without select");
   a_lamp_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      configReg[POS_LAMP_SEL] && !lampReg[POS_LAMP_ON] |=> !lampDriverPin)
      else $error("lamp not off");
   a_lamp_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_LAMP |=> regRdData == $past(lampReg))
      else $error("lamp register read wrong");
   a_config_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_CONFIG |=> configReg == $past(regWrData))
      else $error("config register write wrong");
   a_config_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_CONFIG |=> regRdData == $past(configReg))
      else $error("config register read wrong");

   // interrupt enables
   a_en_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_IRQ_EN |=> irqEnables == ($past(regWrData) & WMASK_IRQ_EN))
      else $error("enable register write wrong");
   a_en_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (irqEnables & ~WMASK_IRQ_EN) == 8'h00)
      else $error("enable reserved bits stored");
   a_en_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_IRQ_EN |=> regRdData == $past(irqEnables))
      else $error("enable register read wrong");
   a_spec_mirror: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ##1 spectralIrqMirror == $past(irqEnables[POS_SPEC_IEN]))
      else $error("spectral enable mirror wrong");

   // event gating into status
   a_sat_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !irqStatus[POS_EV_SAT] && !irqEnables[POS_SAT_IEN] |=> !irqStatus[POS_EV_SAT])
      else $error("saturation status set while disabled");
   a_buf_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !irqStatus[POS_EV_BUF] && !irqEnables[POS_BUF_IEN] |=> !irqStatus[POS_EV_BUF])
      else $error("buffer status set while disabled");
   a_sys_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !irqStatus[POS_EV_SYS] && !irqEnables[POS_SYS_IEN] |=> !irqStatus[POS_EV_SYS])
      else $error("system status set while disabled");
   a_spec_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sourceEvents.spectral && irqEnables[POS_SPEC_IEN] |=> irqStatus[POS_EV_SPEC])
      else $error("spectral event lost");

   // status, mask and output level
   a_status_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_IRQ_STATUS && regWrData[POS_EV_SAT]
      && !sourceEvents.saturation |=> !irqStatus[POS_EV_SAT])
      else $error("status bit not cleared");
   a_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
      irqStatus[POS_EV_SYS] && !(regWrite && regAddr == OFS_IRQ_STATUS)
      |=> irqStatus[POS_EV_SYS])
      else $error("status bit lost");
   a_status_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_IRQ_STATUS |=> regRdData == {4'h0, $past(irqStatus)})
      else $error("status register read wrong");
   a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_IRQ_MASK |=> irqMask == $past(regWrData[3:0]))
      else $error("mask register write wrong");
   a_mask_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regRead && regAddr == OFS_IRQ_MASK |=> regRdData == {4'h0, $past(irqMask)})
      else $error("mask register read wrong");
   a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
      irqStatus == 4'h0 |-> !irqOut)
      else $error("interrupt without status");

   // one-shot actions and read bus idle
   a_zero_origin: assert property (@(posedge sys_clk) disable iff (!rst_b)
      actionPulses.manualZeroStart |-> $past(regWrite) && $past(regAddr) == OFS_ACTION
      && $past(regWrData[POS_ZERO]))
      else $error("autozero without write");
   a_wake_origin: assert property (@(posedge sys_clk) disable iff (!rst_b)
      actionPulses.wakeFromIrqSleep |-> $past(regWrite) && $past(regAddr) == OFS_ACTION
      && $past(regWrData[POS_WAKE]))
      else $error("wake without write");
   a_flush_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
      regWrite && regAddr == OFS_ACTION && regWrData[POS_FLUSH] |=> actionPulses.bufferFlush)
      else $error("flush pulse missing");
   a_action_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !regWrite |=> actionPulses == 3'b000)
      else $error("action pulse without write");
   a_read_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !regRead |=> regRdData == 8'h00)
      else $error("read data outside read cycle");
endmodule

// ==== tb/test_sensor_pin_lamp_irq_control.sv ====
`timescale 1ns/1ps
// compare one value, count it, report a mismatch
`define CHK(nm, ex, got) \
   begin \
      nTests++; \
      if ((got) !== (ex)) begin \
         failCount++; \
         $display("ERROR %s expected %h seen %h", nm, ex, got); \
      end \
   end
module test_sensor_pin_lamp_irq_control;
   import sensor_ctrl_pkg::*;
   logic sys_clk;
   logic rst_b;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic [7:0] regRdData;
   logic regWrite;
   logic regRead;
   logic pinIn;
   logic pinOut;
   logic pinOutEn;
   logic lampDriverPin;
   logic [6:0] lampCurrentCode;
   events_t sourceEvents;
   actions_t actionPulses;
   logic spectralIrqMirror;
   logic irqOut;
   int failCount;
   int nTests;
   int i;
   logic [15:0] seed;
   logic [7:0] val;
   logic [7:0] rdVal;

   ////////////////////////////////////////////////////////////////////////
   sensor_pin_lamp_irq_control dut_u (
      .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinIn(pinIn),
      .pinOut(pinOut), .pinOutEn(pinOutEn), .lampDriverPin(lampDriverPin),
      .lampCurrentCode(lampCurrentCode), .sourceEvents(sourceEvents),
      .actionPulses(actionPulses), .spectralIrqMirror(spectralIrqMirror), .irqOut(irqOut)
   );

   ////////////////////////////////////////////////////////////////////////
   // fibonacci shift register for stimulus
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // expected pin register readback
   function automatic logic [7:0] expPin(input logic [7:0] w, input logic p);
      return {4'h0, w[3:1], w[2] & p};
   endfunction
   // enable bit position that gates event number n
   function automatic int enPos(input int n);
      case (n)
         0: return POS_SAT_IEN;
         1: return POS_SPEC_IEN;
         2: return POS_BUF_IEN;
         default: return POS_SYS_IEN;
      endcase
   endfunction

   // register write: returns at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   // register read: data taken in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      rdVal = regRdData;
   endtask
   task automatic wrapUp;
      if (failCount == 0 && nTests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      failCount++;
      $display("ERROR watchdog expected %h seen %h", 1'b0, 1'b1);
      wrapUp();
   end

   // main sequence
   initial begin
      rst_b = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      pinIn = 1'b0;
      sourceEvents = '0;
      failCount = 0;
      nTests = 0;
      seed = 16'h899F;
      repeat (12) @(posedge sys_clk);
      `CHK("lampCurrentCode", RST_LAMP_CODE, lampCurrentCode)
      rst_b <= 1'b1;
      @(posedge sys_clk);
      #1;
      `CHK("pinOut", 1'b1, pinOut)
      `CHK("lampDriverPin", 1'b0, lampDriverPin)
      rd(OFS_PIN);
      `CHK("pin reg", RST_PIN, rdVal)
      rd(OFS_LAMP);
      `CHK("lamp reg", {1'b0, RST_LAMP_CODE}, rdVal)
      rd(OFS_IRQ_EN);
      `CHK("irq enables", 8'h00, rdVal)
      // pin: random settings and levels, corners first
      for (i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         val = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
         @(posedge sys_clk);
         pinIn <= seed[8];
         wr(OFS_PIN, val);
         repeat (4) @(posedge sys_clk);
         #1;
         `CHK("pinOut", val[1] ^ val[3], pinOut)
         `CHK("pinOutEn", !val[2], pinOutEn)
         rd(OFS_PIN);
         `CHK("pin reg", expPin(val, seed[8]), rdVal)
      end
      // lamp: ignored before select, then random codes
      wr(OFS_LAMP, 8'hFF);
      @(posedge sys_clk);
      #1;
      `CHK("lampDriverPin", 1'b0, lampDriverPin)
      wr(OFS_CONFIG, 8'h08);
      for (i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         val = (i == 0) ? 8'h80 : (i == 15) ? 8'hFF : seed[7:0];
         wr(OFS_LAMP, val);
         @(posedge sys_clk);
         #1;
         `CHK("lampDriverPin", val[7], lampDriverPin)
         `CHK("lampCurrentCode", val[6:0], lampCurrentCode)
         rd(OFS_LAMP);
         `CHK("lamp reg", val, rdVal)
      end
      wr(OFS_CONFIG, 8'h00);
      @(posedge sys_clk);
      #1;
      `CHK("lampDriverPin", 1'b0, lampDriverPin)
      // events: one enable at a time, all sources firing
      wr(OFS_IRQ_MASK, 8'h0F);
      for (i = 0; i < 4; i++) begin
         wr(OFS_IRQ_EN, 8'h01 << enPos(i));
         @(posedge sys_clk);
         #1;
         `CHK("spectralIrqMirror", (i == 1), spectralIrqMirror)
         @(posedge sys_clk);
         sourceEvents <= 4'hF;
         @(posedge sys_clk);
         sourceEvents <= '0;
         #1;
         `CHK("irqOut", 1'b1, irqOut)
         rd(OFS_IRQ_STATUS);
         `CHK("irq status", 8'h01 << i, rdVal)
         wr(OFS_IRQ_STATUS, 8'h01 << i);
         #1;
         `CHK("irqOut", 1'b0, irqOut)
      end
      // masking of the output, reserved enable bits
      wr(OFS_IRQ_EN, 8'hFF);
      rd(OFS_IRQ_EN);
      `CHK("irq enables", WMASK_IRQ_EN, rdVal)
      wr(OFS_IRQ_MASK, 8'h00);
      @(posedge sys_clk);
      sourceEvents <= 4'hF;
      @(posedge sys_clk);
      sourceEvents <= '0;
      #1;
      `CHK("irqOut", 1'b0, irqOut)
      rd(OFS_IRQ_STATUS);
      `CHK("irq status", 8'h0F, rdVal)
      wr(OFS_IRQ_MASK, 8'h04);
      @(posedge sys_clk);
      #1;
      `CHK("irqOut", 1'b1, irqOut)
      wr(OFS_IRQ_STATUS, 8'hFF);
      #1;
      `CHK("irqOut", 1'b0, irqOut)
      // actions, spectral run taken as already stopped
      for (i = 0; i < 5; i++) begin
         val = (i < 4) ? (8'h01 << i) : 8'hFF;
         wr(OFS_ACTION, val);
         #1;
         `CHK("actionPulses", val[2:0], actionPulses)
         @(posedge sys_clk);
         #1;
         `CHK("actionPulses", 3'b000, actionPulses)
         rd(OFS_ACTION);
         `CHK("action reg", 8'h00, rdVal)
      end
      // unmapped place
      wr(8'h00, 8'hFF);
      rd(8'h00);
      `CHK("unmapped", 8'h00, rdVal)
      wrapUp();
   end
endmodule
